//--- logic/tio_params.svh
// offsets, field positions, reset values and widths for the timed i/o block
// assumes apb byte addressing with one 32-bit register per aligned word
`ifndef TIO_PARAMS_SVH
`define TIO_PARAMS_SVH
`define TIO_NPORT 5
`define TIO_NCB 6
`define TIO_NPIN 32
`define TIO_PW0 1
`define TIO_PW1 4
`define TIO_PW2 8
`define TIO_PW3 16
`define TIO_PW4 32
`define TIO_LINK_LO 24
`define TIO_PORT_STRIDE_SH 5
`define TIO_REG_CTRL 3'h0
`define TIO_REG_DATA 3'h1
`define TIO_REG_STAT 3'h2
`define TIO_REG_CNT 3'h3
`define TIO_REG_TIME 3'h4
`define TIO_REG_TSTAMP 3'h5
`define TIO_REG_COND 3'h6
`define TIO_AREA_PORT 4'h0
`define TIO_AREA_CB 4'h1
`define TIO_AREA_GLB 4'h2
`define TIO_CTRL_EN 0
`define TIO_CTRL_OUT 1
`define TIO_CTRL_OD 2
`define TIO_CTRL_TIMED 3
`define TIO_CTRL_COND_LO 4
`define TIO_CTRL_STRB_IN 6
`define TIO_CTRL_STRB_OUT 7
`define TIO_CTRL_CB_LO 8
`define TIO_CTRL_W 11
`define TIO_CTRL_RST 11'h000
`define TIO_CB_SRC_EXT 8
`define TIO_CB_DIV_EN 9
`define TIO_CB_W 10
`define TIO_CB_RST 10'h000
`endif

//--- logic/tio_pkg.sv
// types shared by the timed i/o block
// assumes tio_params.svh for all numeric constants
package tio_pkg;
  typedef enum logic [1:0] {COND_NONE, COND_EQ, COND_NEQ, COND_RSVD} cond_mode_t;
  typedef logic [15:0] port_count_t;
endpackage : tio_pkg

//--- logic/timed_io_port.sv
// timed serialising i/o ports (1/4/8/16/32 bit) with six clock blocks, apb registers
// assumes REF_CLK 25 MHz, RST_N synchronous active low, pins asynchronous to REF_CLK
// Operation
// - ports of width one, four, eight, sixteen and thirty-two bits on pins
// - all pins of one port share one direction
// - port drives pins or samples them, optionally waiting for a condition
// - each port access completes within one processor cycle
// - open drain: zero pulls low, one leaves the pin undriven
// - data passes through shift register plus transfer register per port
// - each port has a sixteen bit counter timing transfers
// - counter readable anytime; a count can delay input or output
// - each transfer latches the counter as a readable timestamp
// - enabled link disables ports on its shared pins
// - enabled narrower port wins over wider ports on shared pins
// - unshared pins of a wider port stay usable by it
// - a port always transfers at its own full width
// - six clock blocks; block zero is reference, others independently set
// - a clock block may take a one bit port as clock source
// - a clock block fed from a pin may divide that clock
// - ports accept an incoming strobe and emit a strobe with output
// - after reset every port uses clock block zero
// - pin events go to the scheduler as event lines, not interrupts
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "tio_params.svh"
module timed_io_port (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [`TIO_NPIN-1:0] PIN_I,
  output logic [`TIO_NPIN-1:0] PIN_O,
  output logic [`TIO_NPIN-1:0] PIN_OE,
  input wire logic STROBE_IN,
  output logic STROBE_OUT,
  output logic [`TIO_NPORT-1:0] EVENT
);
  // port widths, all based at pin 0
  localparam int PW [`TIO_NPORT] = '{`TIO_PW0, `TIO_PW1, `TIO_PW2, `TIO_PW3, `TIO_PW4};

  // two-flop synchronisers; first stage feeds only the second
  logic [31:0] pin_m_q, pin_s_q;
  logic strb_m_q, strb_s_q, clk_pin_d_q;
  always_ff @(posedge REF_CLK) begin
    pin_m_q <= PIN_I;
    pin_s_q <= pin_m_q;
    strb_m_q <= STROBE_IN;
    strb_s_q <= strb_m_q;
    clk_pin_d_q <= pin_s_q[0];
  end
  // rising edge of the one bit port pin as clock source
  wire ext_edge = pin_s_q[0] & ~clk_pin_d_q;

  // apb decode; ready is a flop so every access takes one wait-free access cycle
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  wire setup = PSEL & ~PENABLE;
  wire done = PSEL & PENABLE & pready_q;
  wire [3:0] area = PADDR[11:8];
  wire [2:0] pidx = PADDR[7:5];
  wire [2:0] preg = PADDR[4:2];
  wire is_port = (area == `TIO_AREA_PORT) && (pidx < 3'(`TIO_NPORT)) && (preg <= `TIO_REG_COND);
  wire is_cb = (area == `TIO_AREA_CB) && (PADDR[7:5] == 3'h0) && (preg < 3'(`TIO_NCB));
  wire is_glb = (area == `TIO_AREA_GLB) && (PADDR[7:2] == 6'h00);
  wire wr = done & PWRITE;
  wire rd = done & ~PWRITE;

  // per port state visible to the shared logic
  logic [`TIO_CTRL_W-1:0] ctrl_q [`TIO_NPORT];
  logic [15:0] cnt_q [`TIO_NPORT];
  logic [15:0] time_q [`TIO_NPORT];
  logic [15:0] tstamp_q [`TIO_NPORT];
  logic [31:0] cond_q [`TIO_NPORT];
  logic [31:0] rx_q [`TIO_NPORT];
  logic [`TIO_NPORT-1:0] tx_full_q, rx_full_q, met_q, evt_q, strb_pulse_q, load_now;
  logic [31:0] out_q [`TIO_NPORT];
  logic [`TIO_CB_W-1:0] cb_q [`TIO_NCB];
  logic [7:0] div_q [`TIO_NCB];
  logic [`TIO_NCB-1:0] cb_tick;
  logic link_en_q;

  // read mux; refused write of a full transfer register also errors
  logic [31:0] rd_val;
  logic bad;
  always_comb begin
    rd_val = 32'h0000_0000;
    bad = ~(is_port | is_cb | is_glb);
    if (is_port) begin
      unique case (preg)
        `TIO_REG_CTRL: rd_val = 32'(ctrl_q[pidx]);
        `TIO_REG_DATA: rd_val = rx_q[pidx];
        `TIO_REG_STAT: rd_val = {29'h0, met_q[pidx], rx_full_q[pidx], tx_full_q[pidx]};
        `TIO_REG_CNT: rd_val = {16'h0, cnt_q[pidx]};
        `TIO_REG_TIME: rd_val = {16'h0, time_q[pidx]};
        `TIO_REG_TSTAMP: rd_val = {16'h0, tstamp_q[pidx]};
        default: rd_val = cond_q[pidx];
      endcase
      bad = PWRITE && (preg == `TIO_REG_DATA) && tx_full_q[pidx];
    end else if (is_cb) begin
      rd_val = 32'(cb_q[preg]);
    end else if (is_glb) begin
      rd_val = {31'h0, link_en_q};
    end
  end

  // answer registered in the setup cycle, access ends next edge
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      link_en_q <= 1'b0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & bad;
      if (setup) prdata_q <= PWRITE ? 32'h0000_0000 : rd_val;
      if (wr && is_glb) link_en_q <= PWDATA[0];
    end
  end

  // six clock blocks; block zero ticks on every reference edge
  genvar k;
  generate
    for (k = 0; k < `TIO_NCB; k++) begin : g_cb
      if (k == 0) begin : g_ref
        assign cb_tick[k] = 1'b1;
        assign cb_q[k] = `TIO_CB_RST;
        assign div_q[k] = 8'h00;
      end else begin : g_prog
        logic [`TIO_CB_W-1:0] cfg_q;
        logic [7:0] dcnt_q;
        // external source optionally divided by cfg+1 edges
        wire src_ev = cfg_q[`TIO_CB_SRC_EXT] ? ext_edge : 1'b1;
        wire div_hit = ~cfg_q[`TIO_CB_DIV_EN] | (dcnt_q == cfg_q[7:0]);
        assign cb_tick[k] = src_ev & div_hit;
        assign cb_q[k] = cfg_q;
        assign div_q[k] = dcnt_q;
        always_ff @(posedge REF_CLK) begin
          if (!RST_N) begin
            cfg_q <= `TIO_CB_RST;
            dcnt_q <= 8'h00;
          end else begin
            if (wr && is_cb && preg == 3'(k)) cfg_q <= PWDATA[`TIO_CB_W-1:0];
            if (cb_tick[k]) dcnt_q <= 8'h00;
            else if (src_ev) dcnt_q <= dcnt_q + 8'h01;
          end
        end
      end
    end
  endgenerate

  // per port: counter, transfer register, shifter, condition and timestamp
  genvar i;
  generate
    for (i = 0; i < `TIO_NPORT; i++) begin : g_port
      localparam int W = PW[i];
      localparam logic [5:0] NSTEP = 6'(32 / W);
      logic [31:0] tx_q, sh_q;
      logic [5:0] n_q;
      wire wsel = wr && is_port && pidx == 3'(i);
      wire rsel = rd && is_port && pidx == 3'(i);
      wire tick = cb_tick[ctrl_q[i][`TIO_CTRL_CB_LO +: 3]];
      wire is_out = ctrl_q[i][`TIO_CTRL_OUT];
      wire [31:0] mask = (W == 32) ? 32'hffff_ffff : ((32'h1 << W) - 32'h1);
      wire [31:0] pin_v = pin_s_q & mask;
      tio_pkg::cond_mode_t cmode;
      assign cmode = tio_pkg::cond_mode_t'(ctrl_q[i][`TIO_CTRL_COND_LO +: 2]);
      // wait condition on the sampled pin value
      wire cond_ok = (cmode == tio_pkg::COND_NONE) || (cmode == tio_pkg::COND_RSVD)
                     || ((cmode == tio_pkg::COND_EQ) && (pin_v == (cond_q[i] & mask)))
                     || ((cmode == tio_pkg::COND_NEQ) && (pin_v != (cond_q[i] & mask)));
      // a timed transfer waits for the counter to match
      wire time_ok = ~ctrl_q[i][`TIO_CTRL_TIMED] || (cnt_q[i] == time_q[i]);
      // strobed input samples only while the strobe is high
      wire strb_ok = ~ctrl_q[i][`TIO_CTRL_STRB_IN] | strb_s_q;
      wire en = ctrl_q[i][`TIO_CTRL_EN];
      wire out_load = en & is_out & tick & (n_q == 6'h0) & tx_full_q[i] & time_ok;
      wire out_step = en & is_out & tick & (n_q != 6'h0);
      wire in_start = en & ~is_out & tick & (n_q == 6'h0) & ~rx_full_q[i]
                      & cond_ok & time_ok & strb_ok;
      wire in_step = en & ~is_out & tick & (n_q != 6'h0) & strb_ok;
      wire [31:0] sh_in = (W == 32) ? pin_v : ((sh_q >> W) | (pin_v << (32 - W)));
      wire in_last = (in_start | in_step) & ((n_q + 6'h1) == NSTEP);
      assign load_now[i] = out_load;
      always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
          // clock select field resets to block zero
          ctrl_q[i] <= `TIO_CTRL_RST;
          cnt_q[i] <= 16'h0000;
          time_q[i] <= 16'h0000;
          tstamp_q[i] <= 16'h0000;
          cond_q[i] <= 32'h0000_0000;
          rx_q[i] <= 32'h0000_0000;
          tx_q <= 32'h0000_0000;
          sh_q <= 32'h0000_0000;
          n_q <= 6'h0;
          out_q[i] <= 32'h0000_0000;
          tx_full_q[i] <= 1'b0;
          rx_full_q[i] <= 1'b0;
          met_q[i] <= 1'b0;
          evt_q[i] <= 1'b0;
          strb_pulse_q[i] <= 1'b0;
        end else begin
          // free-running count per clock block tick, wraps
          if (tick) cnt_q[i] <= cnt_q[i] + 16'h0001;
          if (wsel && preg == `TIO_REG_CTRL) ctrl_q[i] <= PWDATA[`TIO_CTRL_W-1:0];
          if (wsel && preg == `TIO_REG_TIME) time_q[i] <= PWDATA[15:0];
          if (wsel && preg == `TIO_REG_COND) cond_q[i] <= PWDATA;
          // write fills the transfer register; refused while full
          if (wsel && preg == `TIO_REG_DATA && !tx_full_q[i]) begin
            tx_q <= PWDATA;
            tx_full_q[i] <= 1'b1;
          end else if (out_load) begin
            tx_full_q[i] <= 1'b0;
          end
          // the shifter always runs the full 32-bit word
          if (out_load) begin
            out_q[i] <= tx_q & mask;
            sh_q <= (W == 32) ? 32'h0 : (tx_q >> W);
            n_q <= NSTEP - 6'h1;
          end else if (out_step) begin
            out_q[i] <= sh_q & mask;
            sh_q <= (W == 32) ? 32'h0 : (sh_q >> W);
            n_q <= n_q - 6'h1;
          end else if (in_start | in_step) begin
            sh_q <= sh_in;
            n_q <= in_last ? 6'h0 : (n_q + 6'h1);
          end
          // timestamp taken on every word transfer
          if (out_load || in_last) tstamp_q[i] <= cnt_q[i];
          // one-shot timing: the timed flag drops once used
          if (out_load || in_start) ctrl_q[i][`TIO_CTRL_TIMED] <= 1'b0;
          // collecting flag: last sample wins, so a one-step word leaves it clear
          met_q[i] <= in_last ? 1'b0 : (in_start ? 1'b1 : met_q[i]);
          // new data wins over a read that clears the flag in the same cycle
          if (in_last) begin
            rx_q[i] <= sh_in;
            rx_full_q[i] <= 1'b1;
          end else if (rsel && preg == `TIO_REG_DATA) begin
            rx_full_q[i] <= 1'b0;
          end
          // pulse to the scheduler on data in or word taken out
          evt_q[i] <= in_last | out_load;
          strb_pulse_q[i] <= (out_load | out_step) & ctrl_q[i][`TIO_CTRL_STRB_OUT];
        end
      end
    end
  endgenerate

  // pin ownership: link first, then the narrowest enabled port covering the pin
  logic [31:0] pin_o_d, pin_oe_d, od_d;
  genvar j;
  generate
    for (j = 0; j < `TIO_NPIN; j++) begin : g_pin
      always_comb begin
        pin_o_d[j] = 1'b0;
        pin_oe_d[j] = 1'b0;
        od_d[j] = 1'b0;
        // narrower enabled port wins; rest stays with wider
        for (int p = `TIO_NPORT - 1; p >= 0; p--) begin
          if (ctrl_q[p][`TIO_CTRL_EN] && j < PW[p]) begin
            od_d[j] = ctrl_q[p][`TIO_CTRL_OD];
            // one direction bit per port drives all its pins
            // open drain drives only a zero
            pin_o_d[j] = ctrl_q[p][`TIO_CTRL_OD] ? 1'b0 : out_q[p][j];
            pin_oe_d[j] = ctrl_q[p][`TIO_CTRL_OUT]
                          & ~(ctrl_q[p][`TIO_CTRL_OD] & out_q[p][j]);
          end
        end
        // link takes its pins away from every port
        if (link_en_q && j >= `TIO_LINK_LO) begin
          pin_o_d[j] = 1'b0;
          pin_oe_d[j] = 1'b0;
        end
      end
    end
  endgenerate

  // pin drivers are flops to keep output timing clean at the pads
  logic [31:0] pin_o_q, pin_oe_q;
  logic strobe_q;
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      pin_o_q <= 32'h0000_0000;
      pin_oe_q <= 32'h0000_0000;
      strobe_q <= 1'b0;
    end else begin
      pin_o_q <= pin_o_d;
      pin_oe_q <= pin_oe_d;
      strobe_q <= |strb_pulse_q;
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign PIN_O = pin_o_q;
  assign PIN_OE = pin_oe_q;
  assign STROBE_OUT = strobe_q;
  assign EVENT = evt_q;

  // checks
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_access;
    PSEL && PENABLE && PREADY;
  endsequence
  property p_apb_one_cycle;
    @(posedge REF_CLK) disable iff (!RST_N) s_setup ##1 PENABLE |-> PREADY;
  endproperty
  a_apb_one_cycle: assert property (p_apb_one_cycle) else $error("apb access not ready");
  property p_apb_release;
    @(posedge REF_CLK) disable iff (!RST_N) s_access |=> !PREADY;
  endproperty
  a_apb_release: assert property (p_apb_release) else $error("ready held too long");
  property p_cnt_wrap;
    @(posedge REF_CLK) disable iff (!RST_N)
      (cb_tick[ctrl_q[0][`TIO_CTRL_CB_LO +: 3]] && cnt_q[0] == 16'hffff) |=> cnt_q[0] == 16'h0000;
  endproperty
  a_cnt_wrap: assert property (p_cnt_wrap) else $error("counter did not wrap");
  property p_cnt_step;
    @(posedge REF_CLK) disable iff (!RST_N)
      (cb_tick[ctrl_q[1][`TIO_CTRL_CB_LO +: 3]] && !(wr && is_port))
      |=> cnt_q[1] == $past(cnt_q[1]) + 16'h0001;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("counter missed a tick");
  property p_tstamp;
    @(posedge REF_CLK) disable iff (!RST_N) load_now[0] |=> tstamp_q[0] == $past(cnt_q[0]);
  endproperty
  a_tstamp: assert property (p_tstamp) else $error("timestamp not latched");
  property p_timed;
    @(posedge REF_CLK) disable iff (!RST_N)
      (load_now[0] && ctrl_q[0][`TIO_CTRL_TIMED]) |-> cnt_q[0] == time_q[0];
  endproperty
  a_timed: assert property (p_timed) else $error("timed output early");
  property p_link;
    @(posedge REF_CLK) disable iff (!RST_N) link_en_q |=> PIN_OE[31:24] == 8'h00;
  endproperty
  a_link: assert property (p_link) else $error("port drives a link pin");
  property p_open_drain;
    @(posedge REF_CLK) disable iff (!RST_N) od_d[0] |=> !(PIN_OE[0] && PIN_O[0]);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drove high");
  property p_narrow;
    @(posedge REF_CLK) disable iff (!RST_N)
      (ctrl_q[0][`TIO_CTRL_EN] && ctrl_q[0][`TIO_CTRL_OUT] && !ctrl_q[0][`TIO_CTRL_OD])
      |=> PIN_OE[0] && PIN_O[0] == $past(out_q[0][0]);
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow port lost its pin");
  property p_event;
    @(posedge REF_CLK) disable iff (!RST_N) $rose(rx_full_q[2]) |-> EVENT[2];
  endproperty
  a_event: assert property (p_event) else $error("no event for input word");
  property p_tstamp_in;
    @(posedge REF_CLK) disable iff (!RST_N)
      g_port[2].in_last |=> tstamp_q[2] == $past(cnt_q[2]);
  endproperty
  a_tstamp_in: assert property (p_tstamp_in) else $error("input stamp not latched");
  property p_strobe;
    @(posedge REF_CLK) disable iff (!RST_N) (|strb_pulse_q) |=> STROBE_OUT;
  endproperty
  a_strobe: assert property (p_strobe) else $error("output step without strobe");
  property p_reset_cb;
    @(posedge REF_CLK) !RST_N |=> ctrl_q[4][`TIO_CTRL_CB_LO +: 3] == 3'h0;
  endproperty
  a_reset_cb: assert property (p_reset_cb) else $error("reset left a clock select");
endmodule : timed_io_port

//--- tb/pin_partner.sv
// model of the application hardware on the port pins
// assumes pins are pulled down wherever nobody drives them
`timescale 1ns/1ps
module pin_partner (
  input wire logic clk,
  input wire logic [31:0] pin_o,
  input wire logic [31:0] pin_oe,
  input wire logic strobe_out,
  input wire logic [31:0] drv_val,
  input wire logic drv_en,
  input wire logic clr,
  output logic [31:0] pin_i,
  output logic strobe_in,
  output int strb_cnt,
  output logic [31:0] cap_word
);
  // pin level: device wins where enabled, else our drive or pull-down
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & (drv_en ? drv_val : 32'h0));
  // our strobe rides with our data
  assign strobe_in = drv_en;
  // take pin 0 on every device strobe, lsb arrives first
  always_ff @(posedge clk) begin
    if (clr) begin
      strb_cnt <= 0;
      cap_word <= 32'h0;
    end else if (strobe_out === 1'b1) begin
      strb_cnt <= strb_cnt + 1;
      cap_word <= {pin_o[0], cap_word[31:1]};
    end
  end
endmodule : pin_partner

//--- tb/tb_timed_io_port.sv
// self-checking bench for the timed i/o ports
// assumes zero-wait apb and port i pins starting at pin 0
`timescale 1ns/1ps
`include "tio_params.svh"
module tb_timed_io_port;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic strobe_in, strobe_out, drv_en, clr;
  logic [11:0] paddr;
  logic [15:0] c;
  logic [31:0] pwdata, prdata, pin_i, pin_o, pin_oe, drv_val, cap_word, rv;
  logic [`TIO_NPORT-1:0] evt;
  int strb_cnt;
  int error_cnt = 0;
  int samples_checked = 0;

  timed_io_port timed_io_port_inst (.REF_CLK(ref_clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE(pin_oe),
    .STROBE_IN(strobe_in), .STROBE_OUT(strobe_out), .EVENT(evt));
  pin_partner pin_partner_inst (.clk(ref_clk), .pin_o(pin_o), .pin_oe(pin_oe),
    .strobe_out(strobe_out), .drv_val(drv_val), .drv_en(drv_en), .clr(clr),
    .pin_i(pin_i), .strobe_in(strobe_in), .strb_cnt(strb_cnt), .cap_word(cap_word));

  // 25 MHz reference
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic final_report;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  task automatic bad(input string m);
    error_cnt++;
    $display("BAD %0t %s", $time, m);
  endtask : bad

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      bad(m);
    end
  endtask : chk

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cycles

  // one apb transfer; holds everything until pready is seen high or 17 access edges pass without it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
      n++;
      if (n > 16) begin
        bad("no ready");
        break;
      end
    end
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n != 0) begin
      bad("wait state");
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic clr_partner;
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
  endtask : clr_partner

  // bounded waits: event pulse of a port, strobe count of the partner
  task automatic wait_evt(input int i);
    int n;
    for (n = 0; n < 200 && evt[i] !== 1'b1; n++) @(posedge ref_clk);
    if (n == 200) begin
      bad("no event");
    end
  endtask : wait_evt

  task automatic wait_cnt(input int k);
    int n;
    for (n = 0; n < 300 && strb_cnt < k; n++) @(posedge ref_clk);
    if (n == 300) begin
      bad("few strobes");
    end
  endtask : wait_cnt

  task automatic t_reset;
    chk(pin_oe, 32'h0, "oe after reset");
    rd(12'h000);
    chk(rv, 32'h0, "ctrl reset");
    wr(12'h100, 32'h3ff);
    rd(12'h100);
    chk(rv, 32'h0, "block 0 fixed");
    rd(12'h3f0);
    chk({rv[30:0], err}, 32'h1, "unmapped");
  endtask : t_reset

  task automatic t_serial;
    clr_partner;
    wr(12'h000, 32'h083);
    wr(12'h004, 32'hc000_0005);
    wait_evt(0);
    wait_cnt(32);
    cycles(4);
    chk(32'(strb_cnt), 32'd32, "step count");
    chk(cap_word, 32'hc000_0005, "serial word");
    chk({30'h0, pin_oe[0], pin_o[0]}, 32'h3, "last bit held");
    rd(12'h00c);
    c = rv[15:0];
    rd(12'h00c);
    chk({16'h0, rv[15:0] - c}, 32'h3, "count step");
  endtask : t_serial

  task automatic t_timed;
    rd(12'h00c);
    c = rv[15:0] + 16'h003c;
    wr(12'h010, {16'h0, c});
    wr(12'h000, 32'h08b);
    clr_partner;
    wr(12'h004, 32'h0000_00ff);
    cycles(20);
    chk(32'(strb_cnt), 32'h0, "early output");
    wait_cnt(32);
    rd(12'h014);
    chk({16'h0, rv[15:0]}, {16'h0, c}, "stamp");
  endtask : t_timed

  task automatic t_opendrain;
    wr(12'h000, 32'h0);
    clr_partner;
    wr(12'h020, 32'h087);
    wr(12'h024, 32'ha000_0000);
    wait_cnt(8);
    cycles(3);
    chk({28'h0, pin_oe[3:0]}, 32'h5, "od enables");
    chk({28'h0, pin_o[3:0] & pin_oe[3:0]}, 32'h0, "od low");
    wr(12'h020, 32'h0);
  endtask : t_opendrain

  task automatic t_input;
    drv_val <= 32'h5a5a_5a5a;
    drv_en <= 1'b1;
    wr(12'h058, 32'h3c);
    wr(12'h040, 32'h011);
    cycles(40);
    rd(12'h048);
    chk(32'(rv[1]), 32'h0, "cond holds off");
    drv_val <= 32'h3c3c_3c3c;
    wait_evt(2);
    drv_val <= 32'h5a5a_5a5a;
    rd(12'h048);
    chk(32'(rv[1]), 32'h1, "rx full");
    rd(12'h044);
    chk(rv, 32'h3c3c_3c3c, "rx word");
    rd(12'h048);
    chk(32'(rv[1]), 32'h0, "rx cleared");
    wr(12'h040, 32'h0);
  endtask : t_input

  task automatic t_extclk;
    drv_val <= 32'h0;
    wr(12'h000, 32'h001);
    wr(12'h104, 32'h301);
    clr_partner;
    wr(12'h060, 32'h183);
    wr(12'h064, 32'h1234_5678);
    cycles(20);
    chk(32'(strb_cnt), 32'h0, "no pin clock");
    // divide by two: four pin edges give two ticks
    repeat (4) begin
      drv_val[0] <= 1'b1;
      cycles(6);
      drv_val[0] <= 1'b0;
      cycles(6);
    end
    chk(32'(strb_cnt), 32'h2, "pin clock steps");
  endtask : t_extclk

  task automatic t_link;
    wr(12'h060, 32'h001);
    wr(12'h000, 32'h0);
    drv_en <= 1'b0;
    wr(12'h200, 32'h1);
    wr(12'h080, 32'h003);
    wr(12'h084, 32'hffff_ffff);
    wait_evt(4);
    cycles(2);
    chk({24'h0, pin_oe[31:24]}, 32'h0, "link pins");
    chk({24'h0, pin_oe[23:16]}, 32'hff, "unshared pins");
    chk({16'h0, pin_oe[15:0]}, 32'h0, "narrow wins");
  endtask : t_link

  // two reads three cycles apart plus the gap cross 0xffff and land on 2
  task automatic t_wrap;
    rd(12'h00c);
    c = rv[15:0];
    cycles(int'(16'hffff - c));
    rd(12'h00c);
    chk({16'h0, rv[15:0]}, 32'h2, "count wrap");
  endtask : t_wrap

  // main sequence
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    drv_val = 32'h0;
    drv_en = 1'b0;
    clr = 1'b0;
    cycles(12);
    rst_n <= 1'b1;
    t_reset;
    t_serial;
    t_timed;
    t_opendrain;
    t_input;
    t_extclk;
    t_link;
    t_wrap;
    final_report;
  end

  // watchdog beyond the counter wrap wait of about 65536 cycles
  initial begin
    #(40 * 90000);
    bad("timeout");
    final_report;
  end
endmodule : tb_timed_io_port
